// ==== verilog/sfesc_pkg.sv ====
package sfesc_pkg;
    // Command opcodes seen on the serial link.
    localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
    localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
    localparam logic [7:0] OP_READ_STATUS = 8'h05;
    localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
    localparam logic [7:0] OP_PROGRAM_ALT = 8'h42;
    localparam logic [7:0] OP_ERASE_ALT = 8'h44;
    localparam logic [7:0] OP_BLOCK32_ERASE = 8'h52;
    localparam logic [7:0] OP_CHIP_ERASE_B = 8'h60;
    localparam logic [7:0] OP_SUSPEND = 8'h75;
    localparam logic [7:0] OP_RESUME = 8'h7a;
    localparam logic [7:0] OP_CHIP_ERASE_A = 8'hc7;
    localparam logic [7:0] OP_BLOCK64_ERASE = 8'hd8;

    // Frame lengths in bits.
    localparam logic [11:0] BITS_OPCODE = 12'h008;
    localparam logic [11:0] BITS_ADDR_CMD = 12'h020;
    localparam logic [11:0] BITS_PROGRAM_MIN = 12'h028;
    localparam logic [11:0] BITS_STATUS_READ = 12'h010;

    // Address space and region sizes as address bit counts.
    localparam int ADDR_W = 24;
    localparam logic [4:0] SECTOR_BITS = 5'd12;
    localparam logic [4:0] BLOCK32_BITS = 5'd15;
    localparam logic [4:0] BLOCK64_BITS = 5'd16;
    localparam logic [4:0] PAGE_BITS = 5'd8;
    localparam logic [24:0] ARRAY_BYTES = 25'h1000000;
    localparam logic [4:0] PROT_UNIT_SHIFT = 5'd15;
    localparam logic [4:0] PROT_FULL_CODE = 5'd9;

    // Status byte layout.
    localparam int STAT_WIP = 0;
    localparam int STAT_WEL = 1;
    localparam int STAT_BP_LO = 2;
    localparam int STAT_SUS = 7;

    // Timing.
    localparam int CLK_PERIOD_NS = 50;
    localparam int NS_PER_US = 1000;
    localparam int LINK_PERIOD_NS = 400;
    localparam int SECTOR_ERASE_TIME_US = 1000;
    localparam int BLOCK_ERASE_TIME_US = 2000;
    localparam int CHIP_ERASE_TIME_US = 100000;
    localparam int PROGRAM_TIME_US = 100;
    localparam int RESUME_WIP_TIME_NS = 200;
    localparam logic [31:0] SECTOR_ERASE_CYCLES =
        32'(SECTOR_ERASE_TIME_US * NS_PER_US / CLK_PERIOD_NS);
    localparam logic [31:0] BLOCK_ERASE_CYCLES =
        32'(BLOCK_ERASE_TIME_US * NS_PER_US / CLK_PERIOD_NS);
    localparam logic [31:0] CHIP_ERASE_CYCLES =
        32'(CHIP_ERASE_TIME_US * NS_PER_US / CLK_PERIOD_NS);
    localparam logic [31:0] PROGRAM_CYCLES = 32'(PROGRAM_TIME_US * NS_PER_US / CLK_PERIOD_NS);
    localparam logic [7:0] RESUME_WIP_CYCLES = 8'(RESUME_WIP_TIME_NS / CLK_PERIOD_NS);
    localparam logic [7:0] LINK_HALF_CYCLES = 8'(LINK_PERIOD_NS / 2 / CLK_PERIOD_NS);

    typedef enum logic [2:0] {
        JOB_NONE, JOB_SECTOR, JOB_BLOCK32, JOB_BLOCK64, JOB_CHIP, JOB_PROGRAM
    } sfesc_job_t;

    typedef enum logic [2:0] {
        HST_IDLE, HST_SETUP, HST_HIGH, HST_LOW, HST_HOLD, HST_GAP
    } sfesc_hstate_t;
endpackage : sfesc_pkg

// ==== verilog/sfesc_link_if.sv ====
`timescale 1ns/10ps
// Serial link between host controller and flash; the host makes the clock.
interface sfesc_link_if;
    logic csB;
    logic sclk;
    logic mosi;
    logic miso;
    modport dev (input csB, input sclk, input mosi, output miso);
    modport host (output csB, output sclk, output mosi, input miso);
endinterface : sfesc_link_if

// ==== verilog/sfesc_flash_dev.sv ====
`timescale 1ns/10ps
// Overview of operation
// - 20h plus address erases containing 4KB sector.
// - 52h plus address erases containing 32KB block.
// - D8h plus address erases containing 64KB block.
// - Host sets write enable before any erase.
// - Host holds select low through whole command.
// - Sector/block erase runs only if select rises after 32 bits.
// - Valid select rise starts timed sector/block erase.
// - Busy flag high during erase; status readable.
// - Write enable latch cleared before erase ends.
// - Protected target region blocks the erase.
// - C7h or 60h erases chip, needs latch.
// - Chip erase needs select rise after eight bits.
// - Chip erase runs timed with busy flag high.
// - Chip erase end clears busy and latch.
// - Chip erase only with protect field zero.
// - 75h suspends running sector/block erase or page program.
// - Host sends no erase/status write while erase-suspended.
// - Suspend ignored during chip erase.
// - Host sends no program/status write while program-suspended.
// - 7Ah accepted only when suspended and idle.
// - Resume clears suspend, sets busy within 200ns.
module sfesc_flash_dev
    import sfesc_pkg::*;
#(
    parameter logic [31:0] SECTOR_CYCLES = sfesc_pkg::SECTOR_ERASE_CYCLES,
    parameter logic [31:0] BLOCK_CYCLES = sfesc_pkg::BLOCK_ERASE_CYCLES,
    parameter logic [31:0] CHIP_CYCLES = sfesc_pkg::CHIP_ERASE_CYCLES,
    parameter logic [31:0] PROG_CYCLES = sfesc_pkg::PROGRAM_CYCLES
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_b,
    // Serial link.
    sfesc_link_if.dev link,
    // Protection field from the non-volatile configuration.
    input wire logic [4:0] protectField,
    // Status and job reporting.
    output logic writeInProgressFlag,
    output logic writeEnableLatch,
    output logic suspendFlag,
    output logic jobDone,
    output sfesc_pkg::sfesc_job_t doneJob,
    output logic [23:0] doneBase,
    output logic cmdRejected
);
    import sfesc_pkg::*;

    typedef struct packed {
        logic [2:0] meta;
        logic [2:0] sync;
        logic sclkPrev;
        logic csPrev;
        logic [31:0] shiftIn;
        logic [11:0] bitCnt;
        logic [7:0] opcode;
        logic [23:0] addrLatch;
        logic [7:0] statusShift;
        logic miso;
        logic write_enable_latch;
        logic busy;
        logic suspend_flag;
        sfesc_job_t job;
        logic [23:0] target;
        logic [31:0] timer;
        logic doneP;
        sfesc_job_t doneJob;
        logic [23:0] doneBase;
        logic rejectP;
    } sfesc_dev_state_t;

    localparam int SYN_SCLK = 2;
    localparam int SYN_CS = 1;
    localparam int SYN_MOSI = 0;

    sfesc_dev_state_t q;
    sfesc_dev_state_t n;
    logic sclkRise;
    logic sclkFall;
    logic csRise;
    logic csLow;
    logic [7:0] statusNow;

    // Clears the low address bits so the base of the containing region results.
    function automatic logic [23:0] alignBase(input logic [23:0] addr, input logic [4:0] bits);
        logic [23:0] mask;
        mask = ~((24'h000001 << bits) - 24'h000001);
        return addr & mask;
    endfunction : alignBase

    // The protected span grows downward from the top of the array; an aligned
    // region whose base sits in the span is covered, since the span edge is
    // always aligned to at least 64KB; at protect code 1 the span is the top 64KB block, which is covered.
    function automatic logic isCovered(input logic [4:0] bp, input logic [23:0] base);
        logic [24:0] span;
        span = (bp >= PROT_FULL_CODE) ? ARRAY_BYTES
             : (25'h0000001 << (PROT_UNIT_SHIFT + bp));
        return (bp != 5'd0) && ({1'b0, base} >= (ARRAY_BYTES - span));
    endfunction : isCovered

    // Link pins are asynchronous, so edges are found only after two flops.
    assign sclkRise = q.sync[SYN_SCLK] & ~q.sclkPrev;
    assign sclkFall = ~q.sync[SYN_SCLK] & q.sclkPrev;
    assign csRise = q.sync[SYN_CS] & ~q.csPrev;
    assign csLow = ~q.sync[SYN_CS];

    // Status byte presented on a status read; live while a job runs.
    always_comb begin
        statusNow = 8'h00;
        statusNow[STAT_WIP] = q.busy;
        statusNow[STAT_WEL] = q.write_enable_latch;
        statusNow[STAT_BP_LO +: 5] = protectField;
        statusNow[STAT_SUS] = q.suspend_flag;
    end

    // Whole next-state of the device.
    always_comb begin
        logic go;
        sfesc_job_t goJob;
        logic [31:0] goTime;
        logic [23:0] goBase;
        logic canStart;
        go = 1'b0;
        goJob = JOB_NONE;
        goTime = 32'h00000000;
        goBase = 24'h000000;
        canStart = q.write_enable_latch && !q.busy && !q.suspend_flag;
        n = q;
        n.meta = {link.sclk, link.csB, link.mosi};
        n.sync = q.meta;
        n.sclkPrev = q.sync[SYN_SCLK];
        n.csPrev = q.sync[SYN_CS];
        n.doneP = 1'b0;
        n.rejectP = 1'b0;

        // Self-timed job; a suspended job keeps its remaining time.
        if (q.busy) begin
            if (q.timer == 32'h00000000) begin
                n.busy = 1'b0;
                n.doneP = 1'b1;
                n.doneJob = q.job;
                n.doneBase = q.target;
                n.job = JOB_NONE;
                if (q.job == JOB_CHIP) begin
                    n.write_enable_latch = 1'b0;
                end
            end else begin
                n.timer = q.timer - 32'h00000001;
            end
        end

        // Bits are taken on the rising link clock, MSB first.
        if (csLow && sclkRise) begin
            n.shiftIn = {q.shiftIn[30:0], q.sync[SYN_MOSI]};
            if (q.bitCnt != 12'hfff) begin
                n.bitCnt = q.bitCnt + 12'h001;
            end
            if (q.bitCnt == BITS_OPCODE - 12'h001) begin
                n.opcode = {q.shiftIn[6:0], q.sync[SYN_MOSI]};
                n.statusShift = statusNow;
            end
            if (q.bitCnt == BITS_ADDR_CMD - 12'h001) begin
                n.addrLatch = {q.shiftIn[22:0], q.sync[SYN_MOSI]};
            end
        end

        // Status goes out on the falling link clock and repeats each byte.
        if (csLow && sclkFall && q.opcode == OP_READ_STATUS && q.bitCnt >= BITS_OPCODE) begin
            n.miso = q.statusShift[7];
            n.statusShift = {q.statusShift[6:0], q.statusShift[7]};
            if (q.bitCnt[2:0] == 3'h0 && q.bitCnt != BITS_OPCODE) begin
                n.miso = statusNow[7];
                n.statusShift = {statusNow[6:0], statusNow[7]};
            end
        end

        // A command acts only when select rises on an exact bit count, or for page program on any whole byte from 40 bits.
        if (csRise) begin
            unique case (q.opcode)
                OP_WRITE_ENABLE: begin
                    if (q.bitCnt == BITS_OPCODE) begin
                        n.write_enable_latch = 1'b1;
                    end
                end
                OP_SECTOR_ERASE, OP_BLOCK32_ERASE, OP_BLOCK64_ERASE: begin
                    goJob = (q.opcode == OP_SECTOR_ERASE) ? JOB_SECTOR
                          : (q.opcode == OP_BLOCK32_ERASE) ? JOB_BLOCK32
                          : JOB_BLOCK64;
                    goBase = alignBase(q.addrLatch, (goJob == JOB_SECTOR) ? SECTOR_BITS
                           : (goJob == JOB_BLOCK32) ? BLOCK32_BITS : BLOCK64_BITS);
                    goTime = (goJob == JOB_SECTOR) ? SECTOR_CYCLES : BLOCK_CYCLES;
                    go = canStart && q.bitCnt == BITS_ADDR_CMD
                       && !isCovered(protectField, goBase);
                end
                OP_CHIP_ERASE_A, OP_CHIP_ERASE_B: begin
                    goJob = JOB_CHIP;
                    goTime = CHIP_CYCLES;
                    go = canStart && q.bitCnt == BITS_OPCODE
                       && protectField == 5'd0;
                end
                OP_PAGE_PROGRAM: begin
                    goJob = JOB_PROGRAM;
                    goBase = alignBase(q.addrLatch, PAGE_BITS);
                    goTime = PROG_CYCLES;
                    go = canStart && q.bitCnt >= BITS_PROGRAM_MIN && q.bitCnt[2:0] == 3'h0
                       && !isCovered(protectField, goBase);
                end
                OP_SUSPEND: begin
                    // A job on its last cycle finishes instead of suspending.
                    if (q.bitCnt == BITS_OPCODE && q.busy && q.timer != 32'h00000000
                        && q.job != JOB_CHIP && q.job != JOB_NONE) begin
                        n.busy = 1'b0;
                        n.suspend_flag = 1'b1;
                        n.timer = q.timer;
                    end
                end
                OP_RESUME: begin
                    if (q.bitCnt == BITS_OPCODE && q.suspend_flag && !q.busy) begin
                        n.suspend_flag = 1'b0;
                        n.busy = 1'b1;
                    end
                end
                default: begin
                end
            endcase
            if (go) begin
                n.busy = 1'b1;
                n.job = goJob;
                n.target = goBase;
                n.timer = goTime - 32'h00000001;
                if (goJob != JOB_CHIP) begin
                    n.write_enable_latch = 1'b0;
                end
            end else if (goJob != JOB_NONE) begin
                n.rejectP = 1'b1;
            end
        end

        // Deselect clears the frame so a broken command never carries over.
        if (q.sync[SYN_CS]) begin
            n.bitCnt = 12'h000;
            n.miso = 1'b0;
            if (!csRise) begin
                n.opcode = 8'h00;
            end
        end
    end

    // Single state register with synchronous reset.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            q <= '0;
            // Idle pin levels: link clock low, select high, data low, so no false edge follows.
            q.meta <= 3'h2;
            q.sync <= 3'h2;
            q.sclkPrev <= 1'b0;
            q.csPrev <= 1'b1;
            q.job <= JOB_NONE;
            q.doneJob <= JOB_NONE;
        end else begin
            q <= n;
        end
    end

    assign link.miso = q.miso;
    assign writeInProgressFlag = q.busy;
    assign writeEnableLatch = q.write_enable_latch;
    assign suspendFlag = q.suspend_flag;
    assign jobDone = q.doneP;
    assign doneJob = q.doneJob;
    assign doneBase = q.doneBase;
    assign cmdRejected = q.rejectP;
endmodule : sfesc_flash_dev

// ==== verilog/sfesc_flash_host.sv ====
`timescale 1ns/10ps
module sfesc_flash_host
    import sfesc_pkg::*;
#(
    parameter logic [7:0] HALF_CYCLES = sfesc_pkg::LINK_HALF_CYCLES
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_b,
    // Command request.
    input wire logic cmdValid,
    input wire logic [7:0] cmdOpcode,
    input wire logic [23:0] cmdAddr,
    input wire logic [7:0] cmdData,
    output logic cmdReady,
    // Command answer.
    output logic rspValid,
    output logic [7:0] rspStatus,
    output logic cmdRefused,
    // Serial link.
    sfesc_link_if.host link
);
    import sfesc_pkg::*;

    typedef struct packed {
        sfesc_hstate_t state;
        logic [7:0] div;
        logic [39:0] shiftOut;
        logic [5:0] bitsLeft;
        logic [5:0] realBits;
        logic [39:0] realFrame;
        logic pendingReal;
        logic sclk;
        logic csB;
        logic mosi;
        logic [1:0] misoSync;
        logic [7:0] rx;
        logic lastErase;
        logic erasePaused;
        logic progPaused;
        logic ready;
        logic rspP;
        logic refusedP;
    } sfesc_host_state_t;

    sfesc_host_state_t q;
    sfesc_host_state_t n;

    // Frame length in link clocks for each opcode.
    function automatic logic [5:0] frameBits(input logic [7:0] op);
        unique case (op)
            OP_SECTOR_ERASE, OP_BLOCK32_ERASE, OP_BLOCK64_ERASE: return BITS_ADDR_CMD[5:0];
            OP_PAGE_PROGRAM: return BITS_PROGRAM_MIN[5:0];
            OP_READ_STATUS: return BITS_STATUS_READ[5:0];
            default: return BITS_OPCODE[5:0];
        endcase
    endfunction : frameBits

    function automatic logic isErase(input logic [7:0] op);
        return op == OP_SECTOR_ERASE || op == OP_BLOCK32_ERASE || op == OP_BLOCK64_ERASE
            || op == OP_CHIP_ERASE_A || op == OP_CHIP_ERASE_B || op == OP_ERASE_ALT;
    endfunction : isErase

    // Whole next-state of the host.
    always_comb begin
        n = q;
        n.misoSync = {q.misoSync[0], link.miso};
        n.rspP = 1'b0;
        n.refusedP = 1'b0;
        n.div = (q.div != 8'h00) ? q.div - 8'h01 : 8'h00;
        unique case (q.state)
            HST_IDLE: begin
                if (cmdValid && q.ready) begin
                    n.ready = 1'b0;
                    n.realFrame = {cmdOpcode, cmdAddr, cmdData};
                    n.realBits = frameBits(cmdOpcode);
                    if ((q.erasePaused && (isErase(cmdOpcode) || cmdOpcode == OP_WRITE_STATUS))
                        || (q.progPaused && (cmdOpcode == OP_PAGE_PROGRAM
                        || cmdOpcode == OP_PROGRAM_ALT || cmdOpcode == OP_WRITE_STATUS))) begin
                        n.refusedP = 1'b1;
                        n.ready = 1'b1;
                    end else begin
                        // Erase and page program always get a write enable frame first.
                        n.pendingReal = isErase(cmdOpcode) || cmdOpcode == OP_PAGE_PROGRAM;
                        n.shiftOut = n.pendingReal ? {OP_WRITE_ENABLE, 32'h00000000}
                                   : {cmdOpcode, cmdAddr, cmdData};
                        n.bitsLeft = n.pendingReal ? BITS_OPCODE[5:0] : frameBits(cmdOpcode);
                        n.state = HST_SETUP;
                        n.div = HALF_CYCLES;
                        n.csB = 1'b0;
                        n.mosi = n.shiftOut[39];
                        if (cmdOpcode == OP_SUSPEND) begin
                            n.erasePaused = q.lastErase;
                            n.progPaused = !q.lastErase;
                        end else if (cmdOpcode == OP_RESUME) begin
                            n.erasePaused = 1'b0;
                            n.progPaused = 1'b0;
                        end else if (n.pendingReal) begin
                            n.lastErase = cmdOpcode != OP_PAGE_PROGRAM;
                        end
                    end
                end
            end
            HST_SETUP, HST_LOW: begin
                if (q.div == 8'h00) begin
                    n.sclk = 1'b1;
                    n.div = HALF_CYCLES;
                    n.state = HST_HIGH;
                end
            end
            HST_HIGH: begin
                if (q.div == 8'h00) begin
                    n.rx = {q.rx[6:0], q.misoSync[1]};
                    n.sclk = 1'b0;
                    n.shiftOut = {q.shiftOut[38:0], 1'b0};
                    n.mosi = q.shiftOut[38];
                    n.bitsLeft = q.bitsLeft - 6'h01;
                    n.div = HALF_CYCLES;
                    n.state = (q.bitsLeft == 6'h01) ? HST_HOLD : HST_LOW;
                end
            end
            HST_HOLD: begin
                // Select rises right after the last bit of the frame.
                if (q.div == 8'h00) begin
                    n.csB = 1'b1;
                    n.mosi = 1'b0;
                    n.div = HALF_CYCLES;
                    n.state = HST_GAP;
                end
            end
            HST_GAP: begin
                if (q.div == 8'h00) begin
                    if (q.pendingReal) begin
                        n.pendingReal = 1'b0;
                        n.shiftOut = q.realFrame;
                        n.bitsLeft = q.realBits;
                        n.csB = 1'b0;
                        n.mosi = q.realFrame[39];
                        n.div = HALF_CYCLES;
                        n.state = HST_SETUP;
                    end else begin
                        n.rspP = 1'b1;
                        n.ready = 1'b1;
                        n.state = HST_IDLE;
                    end
                end
            end
            default: begin
                n.state = HST_IDLE;
            end
        endcase
    end

    // Single state register with synchronous reset.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            q <= '0;
            q.state <= HST_IDLE;
            q.csB <= 1'b1;
            q.ready <= 1'b1;
        end else begin
            q <= n;
        end
    end

    assign link.sclk = q.sclk;
    assign link.csB = q.csB;
    assign link.mosi = q.mosi;
    assign cmdReady = q.ready;
    assign rspValid = q.rspP;
    assign rspStatus = q.rx;
    assign cmdRefused = q.refusedP;
endmodule : sfesc_flash_host

// ==== verification/sfesc_monitor.sv ====
`timescale 1ns/10ps
// Watches the link wires and the flash status; everything lives in the clk domain.
module sfesc_monitor (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_b,
    // Link wires.
    input wire logic csB,
    input wire logic sclk,
    input wire logic mosi,
    input wire logic miso,
    // Flash status.
    input wire logic writeInProgressFlag,
    input wire logic writeEnableLatch,
    input wire logic suspendFlag,
    input wire logic jobDone,
    input wire logic cmdRejected
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    // The link clock stays low outside a frame; the device ignores link clock edges while select is high.
    property p_idle; csB |-> !sclk; endproperty
    a_idle: assert property (p_idle) else $error("link clock moved while deselected");
    property p_hold; sclk |-> $stable(mosi); endproperty
    a_hold: assert property (p_hold) else $error("data changed while link clock high");
    property p_start; $rose(writeInProgressFlag) |-> $past(csB) && $past(csB, 2); endproperty
    a_start: assert property (p_start) else $error("busy rose inside a frame");
    property p_end; $fell(writeInProgressFlag) |-> ##[0:1] (jobDone || suspendFlag); endproperty
    a_end: assert property (p_end) else $error("busy fell without done or suspend");
    property p_wel; jobDone |-> ##[0:1] !writeEnableLatch; endproperty
    a_wel: assert property (p_wel) else $error("latch still set after job");
    property p_excl; !(suspendFlag && writeInProgressFlag); endproperty
    a_excl: assert property (p_excl) else $error("suspended and busy at once");
    property p_resume; $fell(suspendFlag) |-> ##[0:4] writeInProgressFlag; endproperty
    a_resume: assert property (p_resume) else $error("busy late after resume");
    property p_latch; $rose(writeEnableLatch) |-> $past(csB); endproperty
    a_latch: assert property (p_latch) else $error("latch set inside a frame");
    property p_reject; cmdRejected |-> csB; endproperty
    a_reject: assert property (p_reject) else $error("reject before frame end");
endmodule : sfesc_monitor

// ==== verification/testbench.sv ====
`timescale 1ns/10ps
module testbench;
    import sfesc_pkg::*;
    logic clk, rst_b, cmdValid, cmdReady, rspValid, cmdRefused;
    logic write_in_progress_flag, write_enable_latch, suspend_flag, jobDone, cmdRejected;
    logic [7:0] cmdOpcode, cmdData, rspStatus;
    logic [23:0] cmdAddr, doneBase, addr;
    logic [4:0] protectField;
    logic [9:0] hNote;
    logic [27:0] jNote;
    sfesc_job_t doneJob;
    int mismatches = 0;
    int checks = 0;
    int seed;
    logic [9:0] hostQ[$];
    logic [27:0] jobQ[$];
    logic [7:0] ops[5] = '{OP_SECTOR_ERASE, OP_BLOCK32_ERASE, OP_BLOCK64_ERASE,
        OP_CHIP_ERASE_A, OP_CHIP_ERASE_B};
    sfesc_job_t jobs[5] = '{JOB_SECTOR, JOB_BLOCK32, JOB_BLOCK64, JOB_CHIP, JOB_CHIP};
    logic [23:0] masks[5] = '{24'hfff000, 24'hff8000, 24'hff0000, 24'h0, 24'h0};
    sfesc_link_if link ();
    sfesc_flash_host u_sfesc_flash_host (.clk(clk), .rst_b(rst_b), .cmdValid(cmdValid),
        .cmdOpcode(cmdOpcode), .cmdAddr(cmdAddr), .cmdData(cmdData), .cmdReady(cmdReady),
        .rspValid(rspValid), .rspStatus(rspStatus), .cmdRefused(cmdRefused), .link(link.host));
    sfesc_flash_dev #(.SECTOR_CYCLES(32'd800), .BLOCK_CYCLES(32'd1000), .CHIP_CYCLES(32'd1200),
        .PROG_CYCLES(32'd800)) u_sfesc_flash_dev (.clk(clk), .rst_b(rst_b), .link(link.dev),
        .protectField(protectField), .writeInProgressFlag(write_in_progress_flag), .writeEnableLatch(write_enable_latch),
        .suspendFlag(suspend_flag), .jobDone(jobDone), .doneJob(doneJob), .doneBase(doneBase),
        .cmdRejected(cmdRejected));
    sfesc_monitor u_sfesc_monitor (.clk(clk), .rst_b(rst_b), .csB(link.csB), .sclk(link.sclk),
        .mosi(link.mosi), .miso(link.miso), .writeInProgressFlag(write_in_progress_flag), .writeEnableLatch(write_enable_latch),
        .suspendFlag(suspend_flag), .jobDone(jobDone), .cmdRejected(cmdRejected));
    // The clock runs at 20 MHz.
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic test_done();
        if (mismatches == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : test_done
    // Holds the request until the take edge, then waits a bounded time for the answer.
    task automatic send(input logic [7:0] op, input logic [23:0] a, input logic [9:0] note);
        int n;
        hostQ.push_back(note);
        @(posedge clk);
        cmdValid <= 1'b1;
        cmdOpcode <= op;
        cmdAddr <= a;
        @(posedge clk);
        cmdValid <= 1'b0;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (!(rspValid || cmdRefused) && n < 4000);
        if (n >= 4000) mismatches++;
    endtask : send
    task automatic rd(input logic [7:0] st);
        send(OP_READ_STATUS, 24'h0, {2'b01, st});
    endtask : rd
    task automatic wait_idle();
        int n;
        n = 0;
        while (write_in_progress_flag !== 1'b0 && n < 4000) begin
            @(negedge clk);
            n++;
        end
        if (n >= 4000) mismatches++;
    endtask : wait_idle
    // Answers are matched in order against the notes; a reject leaves doneJob stale, so masked.
    always @(posedge clk) begin
        if (rst_b && (rspValid || cmdRefused)) begin
            hNote = hostQ.pop_front();
            check(32'(cmdRefused), 32'(hNote[9]));
            if (hNote[8]) check(32'(rspStatus), 32'(hNote[7:0]));
        end
        if (rst_b && (jobDone || cmdRejected)) begin
            jNote = jobQ.pop_front();
            check(32'(cmdRejected ? 4'h8 : {1'b0, doneJob}), 32'(jNote[27:24]));
            if (!cmdRejected) check(32'(doneBase), 32'(jNote[23:0]));
        end
    end
    // A hang counts as a failure and ends the run in the same place.
    initial begin
        repeat (60000) @(posedge clk);
        mismatches++;
        test_done();
    end
    initial begin
        seed = 32'hd36e;
        rst_b = 1'b0;
        cmdValid = 1'b0;
        cmdOpcode = 8'h00;
        cmdAddr = 24'h0;
        cmdData = 8'h00;
        protectField = 5'h00;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        // Every erase kind at a random address; chip erase keeps the latch until it ends.
        for (int i = 0; i < 5; i++) begin
            addr = 24'($random(seed));
            jobQ.push_back({1'b0, jobs[i], addr & masks[i]});
            send(ops[i], addr, 10'h0);
            rd(i > 2 ? 8'h03 : 8'h01);
            wait_idle();
            rd(8'h00);
        end
        @(posedge clk) protectField <= 5'h09;
        jobQ.push_back({4'h8, 24'h0});
        send(OP_SECTOR_ERASE, 24'($random(seed)), 10'h0);
        @(posedge clk) protectField <= 5'h01;
        jobQ.push_back({4'h8, 24'h0});
        send(OP_CHIP_ERASE_A, 24'h0, 10'h0);
        jobQ.push_back({1'b0, JOB_SECTOR, 24'h001000});
        send(OP_SECTOR_ERASE, 24'h001abc, 10'h0);
        wait_idle();
        @(posedge clk) protectField <= 5'h00;
        // Suspend a block erase, try forbidden orders, then resume it to completion.
        addr = 24'($random(seed));
        jobQ.push_back({1'b0, JOB_BLOCK64, addr & 24'hff0000});
        send(OP_BLOCK64_ERASE, addr, 10'h0);
        send(OP_SUSPEND, 24'h0, 10'h0);
        rd(8'h80);
        send(OP_SECTOR_ERASE, addr, 10'h200);
        send(OP_WRITE_STATUS, addr, 10'h200);
        send(OP_RESUME, 24'h0, 10'h0);
        rd(8'h01);
        wait_idle();
        send(OP_RESUME, 24'h0, 10'h0);
        rd(8'h00);
        send(OP_SUSPEND, 24'h0, 10'h0);
        rd(8'h00);
        send(OP_RESUME, 24'h0, 10'h0);
        // Suspend a page program, try a forbidden program, then resume it to completion.
        jobQ.push_back({1'b0, JOB_PROGRAM, addr & 24'hffff00});
        send(OP_PAGE_PROGRAM, addr, 10'h0);
        send(OP_SUSPEND, 24'h0, 10'h0);
        rd(8'h80);
        send(OP_PAGE_PROGRAM, addr, 10'h200);
        send(OP_RESUME, 24'h0, 10'h0);
        wait_idle();
        jobQ.push_back({1'b0, JOB_CHIP, 24'h0});
        send(OP_CHIP_ERASE_B, 24'h0, 10'h0);
        send(OP_SUSPEND, 24'h0, 10'h0);
        send(OP_RESUME, 24'h0, 10'h0);
        rd(8'h03);
        wait_idle();
        repeat (20) @(posedge clk);
        check(32'(jobQ.size() + hostQ.size()), 32'h0);
        test_done();
    end
endmodule : testbench
